/* rtl/bbc_unit.sv */
// Break-condition unit: channel setup registers, bus matching, break and interrupt.
// Assumes an Avalon-MM master and an observed bus on the same 100 MHz clock.
`include "bbc_consts.svh"
module bbc_unit #(
  parameter int CH_NUM = `BBC_CH_NUM_DFLT,
  parameter int ADDR_W = `BBC_ADDR_W_DFLT
) (
  // Clock and reset
  input logic core_clk_in,
  input logic arst_n_in,
  // Avalon-MM register slave
  input logic [7:0] avs_address_in,
  input logic avs_read_in,
  input logic avs_write_in,
  input logic [31:0] avs_writedata_in,
  input logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // Observed processor bus
  input logic cpu_cycle_in,
  input logic [ADDR_W-1:0] cpu_addr_in,
  input logic [15:0] cpu_data_in,
  input logic cpu_write_in,
  input logic cpu_lane_lo_in,
  input logic cpu_lane_hi_in,
  input logic cpu_fetch_in,
  input logic cpu_exec_done_in,
  input logic [ADDR_W-1:0] cpu_exec_pc_in,
  // Emulator mode
  input logic emu_seq_mode_in,
  // Break and interrupt
  output logic brk_req_out,
  output logic irq_out
);
  import bbc_pkg::*;

  localparam logic [31:0] ADDR_KEEP = 32'((64'h1 << ADDR_W) - 64'h1);

  typedef struct packed {
    bbc_chan_t [CH_NUM-1:0] ch;
    logic [CH_NUM-1:0] configured;
    logic [CH_NUM-1:0] fetched;
    logic [CH_NUM-1:0] status;
    logic [CH_NUM-1:0] irq_mask;
    logic brk;
  } bbc_state_t;

  bbc_state_t st;
  bbc_state_t next_st;
  logic wr_take;
  logic [31:0] rd_word;
  logic [31:0] cur;
  logic [31:0] word;
  logic [CH_NUM-1:0] w1c;
  logic [CH_NUM-1:0] del;
  logic [CH_NUM-1:0] hit;
  logic [CH_NUM-1:0] en_vec;
  logic [CH_NUM-1:0] addr_ok;
  logic [CH_NUM-1:0] qual_ok;
  logic [CH_NUM-1:0] bus_hit;
  logic [CH_NUM-1:0] fetch_hit;
  logic [CH_NUM-1:0] exec_hit;
  logic any_en;
  logic del_any;

  if (CH_NUM < 1 || CH_NUM > `BBC_CH_NUM_MAX || ADDR_W < 1 || ADDR_W > 32) begin : g_bad_param
    $error("bbc_unit: CH_NUM or ADDR_W out of range");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decode helpers

  function automatic logic chan_sel(input logic [7:0] a, input int i);
    logic [7:0] rel;
    rel = a - `BBC_CH_BASE;
    return (a >= `BBC_CH_BASE) && (rel[7:4] == 4'(i));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] chan_word(input bbc_chan_t c, input logic cfgd,
                                            input logic [3:0] off);
    logic [31:0] w;
    w = `BBC_WORD_ZERO;
    case (off)
      `BBC_CH_CTRL: begin
        w[`BBC_CTL_EN] = c.enable;
        w[`BBC_CTL_AIGN] = c.addr_ignore;
        w[`BBC_CTL_AFTER] = c.after_mode;
        w[`BBC_CTL_DIGN] = c.data_ignore;
        w[`BBC_CTL_SIZE_LSB +: 2] = c.size;
        w[`BBC_CTL_DIR_LSB +: 2] = c.dir;
        w[`BBC_CTL_SEQ_LSB +: 3] = c.seq;
        w[`BBC_CTL_CFG] = cfgd;
      end
      `BBC_CH_ADDR: w = c.addr;
      `BBC_CH_AMASK: w = c.amask;
      `BBC_CH_DATA: w[15:0] = c.data;
      default: w = `BBC_WORD_ZERO;
    endcase
    return w;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus slave and per-channel matchers

  bbc_avmm_port u_port (
    .core_clk_in(core_clk_in),
    .arst_n_in(arst_n_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .rd_word_in(rd_word),
    .avs_waitrequest_out(avs_waitrequest_out),
    .avs_readdata_out(avs_readdata_out),
    .wr_take_out(wr_take)
  );

  for (genvar gi = 0; gi < CH_NUM; gi++) begin : g_ch
    bbc_chan_match #(.ADDR_W(ADDR_W)) u_match (
      .cfg_in(st.ch[gi]),
      .cpu_cycle_in(cpu_cycle_in),
      .cpu_addr_in(cpu_addr_in),
      .cpu_data_in(cpu_data_in),
      .cpu_write_in(cpu_write_in),
      .cpu_lane_lo_in(cpu_lane_lo_in),
      .cpu_lane_hi_in(cpu_lane_hi_in),
      .cpu_fetch_in(cpu_fetch_in),
      .cpu_exec_done_in(cpu_exec_done_in),
      .cpu_exec_pc_in(cpu_exec_pc_in),
      .addr_ok_out(addr_ok[gi]),
      .qual_ok_out(qual_ok[gi]),
      .bus_hit_out(bus_hit[gi]),
      .fetch_hit_out(fetch_hit[gi]),
      .exec_hit_out(exec_hit[gi])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    rd_word = `BBC_WORD_ZERO;
    cur = `BBC_WORD_ZERO;
    word = merge(`BBC_WORD_ZERO, avs_writedata_in, avs_byteenable_in);
    w1c = '0;
    del = '0;
    hit = '0;
    en_vec = '0;
    if (avs_address_in == `BBC_REG_STATUS) begin
      rd_word[CH_NUM-1:0] = st.status;
    end else if (avs_address_in == `BBC_REG_IRQ_MASK) begin
      rd_word[CH_NUM-1:0] = st.irq_mask;
    end
    if (wr_take) begin
      if (avs_address_in == `BBC_REG_STATUS) begin
        w1c = word[CH_NUM-1:0];
      end
      if (avs_address_in == `BBC_REG_IRQ_MASK) begin
        next_st.irq_mask = word[CH_NUM-1:0];
      end
      if (avs_address_in == `BBC_REG_CMD) begin
        del = word[`BBC_CMD_DEL_LSB +: CH_NUM];
        if (word[`BBC_CMD_DEL_ALL]) begin
          del = '1;
        end
      end
    end
    for (int i = 0; i < CH_NUM; i++) begin
      en_vec[i] = st.configured[i] & st.ch[i].enable;
      // Enable gates the break only; setup stays untouched
      hit[i] = en_vec[i] & (st.ch[i].after_mode ? (st.fetched[i] & exec_hit[i])
                                                 : bus_hit[i]);
      // Pending fetch resolves at the next completed instruction
      next_st.fetched[i] = st.ch[i].after_mode & st.configured[i] &
                           (fetch_hit[i] | (st.fetched[i] & ~cpu_exec_done_in));
      if (chan_sel(avs_address_in, i)) begin
        cur = chan_word(st.ch[i], st.configured[i], avs_address_in[3:0]);
        rd_word = cur;
        if (wr_take) begin
          word = merge(cur, avs_writedata_in, avs_byteenable_in);
          case (avs_address_in[3:0])
            `BBC_CH_CTRL: begin
              // A channel without conditions cannot be enabled
              next_st.ch[i].enable = word[`BBC_CTL_EN] & st.configured[i];
              next_st.ch[i].addr_ignore = word[`BBC_CTL_AIGN];
              next_st.ch[i].after_mode = word[`BBC_CTL_AFTER];
              next_st.ch[i].data_ignore = word[`BBC_CTL_DIGN];
              next_st.ch[i].size = word[`BBC_CTL_SIZE_LSB +: 2];
              next_st.ch[i].dir = word[`BBC_CTL_DIR_LSB +: 2];
              if (emu_seq_mode_in) begin
                next_st.ch[i].seq = word[`BBC_CTL_SEQ_LSB +: 3];
              end
            end
            `BBC_CH_ADDR: begin
              next_st.ch[i].addr = word & ADDR_KEEP;
              next_st.configured[i] = 1'b1;
            end
            `BBC_CH_AMASK: begin
              next_st.ch[i].amask = word & ADDR_KEEP;
              next_st.configured[i] = 1'b1;
            end
            `BBC_CH_DATA: begin
              next_st.ch[i].data = word[15:0];
              next_st.configured[i] = 1'b1;
            end
            default: begin
              next_st.configured[i] = st.configured[i];
            end
          endcase
        end
      end
      if (del[i]) begin
        next_st.ch[i] = '0;
        next_st.configured[i] = 1'b0;
        next_st.fetched[i] = 1'b0;
      end
    end
    // A break in the clearing cycle survives the clear
    next_st.status = (st.status & ~w1c) | hit;
    next_st.brk = |hit;
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign brk_req_out = st.brk;
  assign irq_out = |(st.status & st.irq_mask);
  assign any_en = |en_vec;
  assign del_any = |del;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks on channel 0 and the break path

  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!arst_n_in);

  a_disabled_silent: assert property (
    brk_req_out |-> $past(any_en))
    else $error("Break raised with no enabled channel");
  a_delete_clears: assert property (
    del_any && del[0] |=> !st.configured[0] && !st.ch[0].enable && st.ch[0].addr == '0)
    else $error("Deleted channel kept its setup");
  a_addr_ignore_ok: assert property (
    st.ch[0].addr_ignore |-> addr_ok[0])
    else $error("Ignored address still restricted the match");
  a_addr_exact: assert property (
    !st.ch[0].addr_ignore && st.ch[0].amask == '0 |->
    addr_ok[0] == (cpu_addr_in == st.ch[0].addr[ADDR_W-1:0]))
    else $error("Plain address compare wrong");
  a_mask_digits: assert property (
    !st.ch[0].addr_ignore |-> addr_ok[0] ==
    (((cpu_addr_in ^ st.ch[0].addr[ADDR_W-1:0]) & ~st.ch[0].amask[ADDR_W-1:0]) == '0))
    else $error("Masked address compare wrong");
  a_after_waits_exec: assert property (
    $rose(st.status[0]) && $past(st.ch[0].after_mode) |-> $past(cpu_exec_done_in))
    else $error("After-mode break without executed instruction");
  a_after_no_bus_hit: assert property (
    st.ch[0].after_mode && st.configured[0] && !del[0] && cpu_cycle_in && cpu_fetch_in &&
    addr_ok[0] |-> !bus_hit[0] ##1 st.fetched[0])
    else $error("After-mode channel used a data, size or direction qualifier");
  a_low_byte_lane: assert property (
    qual_ok[0] && st.ch[0].size == `BBC_SZ_LOW |-> cpu_lane_lo_in && !cpu_lane_hi_in &&
    (st.ch[0].data_ignore || cpu_data_in[7:0] == st.ch[0].data[7:0]))
    else $error("Low byte qualifier wrong");
  a_high_byte_lane: assert property (
    qual_ok[0] && st.ch[0].size == `BBC_SZ_HIGH |-> cpu_lane_hi_in && !cpu_lane_lo_in &&
    (st.ch[0].data_ignore || cpu_data_in[15:8] == st.ch[0].data[7:0]))
    else $error("High byte qualifier wrong");
  a_word_access: assert property (
    qual_ok[0] && st.ch[0].size == `BBC_SZ_WORD |-> cpu_lane_hi_in && cpu_lane_lo_in &&
    (st.ch[0].data_ignore || cpu_data_in == st.ch[0].data))
    else $error("Word qualifier wrong");
  a_data_value: assert property (
    qual_ok[0] && !st.ch[0].data_ignore && st.ch[0].size == `BBC_SZ_WORD |->
    cpu_data_in == st.ch[0].data)
    else $error("Data value not compared");
  a_read_only: assert property (
    qual_ok[0] && st.ch[0].dir == `BBC_DIR_READ |-> !cpu_write_in)
    else $error("Read-only channel took a write");
  a_either_dir: assert property (
    st.ch[0].dir == `BBC_DIR_ANY && st.ch[0].data_ignore && st.ch[0].size == `BBC_SZ_WORD &&
    cpu_lane_lo_in && cpu_lane_hi_in |-> qual_ok[0])
    else $error("Either-direction channel refused a cycle");
  a_seq_locked: assert property (
    !emu_seq_mode_in && !del_any |=> $stable(st.ch[0].seq))
    else $error("Sequence setting changed outside emulation mode");
  a_break_pulse: assert property (
    hit[0] |=> brk_req_out && st.status[0])
    else $error("Channel match did not raise break");

  c_normal_break: cover property (hit[0] && !st.ch[0].after_mode ##1 brk_req_out);
  c_after_break: cover property (fetch_hit[0] ##[1:20] hit[0]);
  c_delete_all: cover property (del_any ##1 st.configured == '0);
  c_irq_rise: cover property ($rose(irq_out));
endmodule

/* pkg/bbc_consts.svh */
// Offsets, field positions, encodings and defaults of the break-condition unit.
// Assumes byte addressing on a 32-bit register bus, one aligned word per register.
`ifndef BBC_CONSTS_SVH
`define BBC_CONSTS_SVH
`define BBC_REG_STATUS 8'h00
`define BBC_REG_IRQ_MASK 8'h04
`define BBC_REG_CMD 8'h08
`define BBC_CH_BASE 8'h20
`define BBC_CH_CTRL 4'h0
`define BBC_CH_ADDR 4'h4
`define BBC_CH_AMASK 4'h8
`define BBC_CH_DATA 4'hc
`define BBC_CMD_DEL_ALL 0
`define BBC_CMD_DEL_LSB 8
`define BBC_CTL_EN 0
`define BBC_CTL_AIGN 1
`define BBC_CTL_AFTER 2
`define BBC_CTL_DIGN 3
`define BBC_CTL_SIZE_LSB 4
`define BBC_CTL_DIR_LSB 6
`define BBC_CTL_SEQ_LSB 8
`define BBC_CTL_CFG 11
`define BBC_SZ_LOW 2'h0
`define BBC_SZ_HIGH 2'h1
`define BBC_SZ_WORD 2'h2
`define BBC_DIR_ANY 2'h0
`define BBC_DIR_READ 2'h1
`define BBC_DIR_WRITE 2'h2
`define BBC_CH_NUM_DFLT 2
`define BBC_CH_NUM_MAX 14
`define BBC_ADDR_W_DFLT 24
`define BBC_WORD_ZERO 32'h0000_0000
`endif

/* pkg/bbc_pkg.sv */
// Types shared by the break-condition unit.
// Assumes the constants header is compiled alongside.
package bbc_pkg;
  typedef struct packed {
    logic enable;
    logic addr_ignore;
    logic after_mode;
    logic data_ignore;
    logic [1:0] size;
    logic [1:0] dir;
    logic [2:0] seq;
    logic [31:0] addr;
    logic [31:0] amask;
    logic [15:0] data;
  } bbc_chan_t;
endpackage

/* rtl/bbc_chan_match.sv */
// Combinational match of one break channel against the observed bus.
// Assumes bus inputs come from logic on the same clock; no synchronising.
`include "bbc_consts.svh"
module bbc_chan_match #(
  parameter int ADDR_W = `BBC_ADDR_W_DFLT
) (
  // Channel setup
  input bbc_pkg::bbc_chan_t cfg_in,
  // Observed processor bus
  input logic cpu_cycle_in,
  input logic [ADDR_W-1:0] cpu_addr_in,
  input logic [15:0] cpu_data_in,
  input logic cpu_write_in,
  input logic cpu_lane_lo_in,
  input logic cpu_lane_hi_in,
  input logic cpu_fetch_in,
  input logic cpu_exec_done_in,
  input logic [ADDR_W-1:0] cpu_exec_pc_in,
  // Results
  output logic addr_ok_out,
  output logic qual_ok_out,
  output logic bus_hit_out,
  output logic fetch_hit_out,
  output logic exec_hit_out
);
  import bbc_pkg::*;

  logic [ADDR_W-1:0] addr_diff;
  logic [ADDR_W-1:0] pc_diff;
  logic size_ok;
  logic data_eq;
  logic dir_ok;

  // Mask bit set means that bit matches anything
  assign addr_diff = (cpu_addr_in ^ cfg_in.addr[ADDR_W-1:0]) & ~cfg_in.amask[ADDR_W-1:0];
  assign pc_diff = (cpu_exec_pc_in ^ cfg_in.addr[ADDR_W-1:0]) & ~cfg_in.amask[ADDR_W-1:0];
  assign addr_ok_out = cfg_in.addr_ignore | (addr_diff == '0);

  always_comb begin
    size_ok = 1'b0;
    data_eq = 1'b0;
    unique case (cfg_in.size)
      `BBC_SZ_LOW: begin
        size_ok = cpu_lane_lo_in & ~cpu_lane_hi_in;
        data_eq = cpu_data_in[7:0] == cfg_in.data[7:0];
      end
      `BBC_SZ_HIGH: begin
        size_ok = cpu_lane_hi_in & ~cpu_lane_lo_in;
        data_eq = cpu_data_in[15:8] == cfg_in.data[7:0];
      end
      `BBC_SZ_WORD: begin
        size_ok = cpu_lane_hi_in & cpu_lane_lo_in;
        data_eq = cpu_data_in == cfg_in.data;
      end
      default: begin
        size_ok = 1'b0;
      end
    endcase
  end

  // Unused direction code behaves as either direction
  assign dir_ok = (cfg_in.dir == `BBC_DIR_READ) ? ~cpu_write_in :
                  (cfg_in.dir == `BBC_DIR_WRITE) ? cpu_write_in : 1'b1;
  assign qual_ok_out = size_ok & (cfg_in.data_ignore | data_eq) & dir_ok;
  // After mode looks at the address only
  assign bus_hit_out = cpu_cycle_in & ~cfg_in.after_mode & addr_ok_out & qual_ok_out;
  assign fetch_hit_out = cpu_cycle_in & cpu_fetch_in & cfg_in.after_mode & addr_ok_out;
  assign exec_hit_out = cpu_exec_done_in & cfg_in.after_mode &
                        (cfg_in.addr_ignore | (pc_diff == '0));
endmodule

/* rtl/bbc_avmm_port.sv */
// Avalon-MM slave handshake: one wait cycle, registered read data.
// Assumes the master holds address, direction and data until waitrequest is low.
module bbc_avmm_port (
  // Clock and reset
  input logic core_clk_in,
  input logic arst_n_in,
  // Bus request
  input logic avs_read_in,
  input logic avs_write_in,
  input logic [31:0] rd_word_in,
  // Bus answer
  output logic avs_waitrequest_out,
  output logic [31:0] avs_readdata_out,
  output logic wr_take_out
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
  } bbc_port_state_t;

  bbc_port_state_t st;
  bbc_port_state_t next_st;
  logic req;

  assign req = avs_read_in | avs_write_in;

  always_comb begin
    next_st = st;
    next_st.ack = req & ~st.ack;
    // Capture in the wait cycle so data stand at the accepting edge
    if (avs_read_in && !st.ack) begin
      next_st.rdata = rd_word_in;
    end
  end

  always_ff @(posedge core_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign avs_waitrequest_out = req & ~st.ack;
  assign avs_readdata_out = st.rdata;
  assign wr_take_out = avs_write_in & st.ack;

  a_wait_one_cycle: assert property (@(posedge core_clk_in) disable iff (!arst_n_in)
    req && avs_waitrequest_out |=> !avs_waitrequest_out)
    else $error("Wait state lasted more than one cycle");
endmodule

/* dv/bbc_cpu_model.sv */
// Behavioural processor bus: observed data cycles and instruction completions.
// Assumes the unit samples these lines on every rising edge of the shared clock.
module bbc_cpu_model #(
  parameter int ADDR_W = 24
) (
  // Clock
  input wire logic core_clk_in,
  // Driven bus
  output logic cpu_cycle_out,
  output logic [ADDR_W-1:0] cpu_addr_out,
  output logic [15:0] cpu_data_out,
  output logic cpu_write_out,
  output logic cpu_lane_lo_out,
  output logic cpu_lane_hi_out,
  output logic cpu_fetch_out,
  output logic cpu_exec_done_out,
  output logic [ADDR_W-1:0] cpu_exec_pc_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    {cpu_cycle_out, cpu_write_out, cpu_lane_lo_out, cpu_lane_hi_out} = 4'h0;
    {cpu_fetch_out, cpu_exec_done_out} = 2'b00;
    {cpu_addr_out, cpu_exec_pc_out, cpu_data_out} = '0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // One bus cycle; released address, data and write lines show the inverse so stale values never match
  task automatic bus(input logic [ADDR_W-1:0] a, input logic [15:0] d,
                     input logic wr, lo, hi, f);
    @(posedge core_clk_in);
    {cpu_cycle_out, cpu_write_out, cpu_lane_lo_out, cpu_lane_hi_out} <= {1'b1, wr, lo, hi};
    cpu_fetch_out <= f;
    {cpu_addr_out, cpu_data_out} <= {a, d};
    @(posedge core_clk_in);
    {cpu_cycle_out, cpu_write_out, cpu_lane_lo_out, cpu_lane_hi_out} <= {1'b0, ~wr, 2'b00};
    cpu_fetch_out <= 1'b0;
    {cpu_addr_out, cpu_data_out} <= {~a, ~d};
  endtask
  // One finished instruction at the given program address
  task automatic done(input logic [ADDR_W-1:0] pc);
    @(posedge core_clk_in);
    {cpu_exec_done_out, cpu_exec_pc_out} <= {1'b1, pc};
    @(posedge core_clk_in);
    {cpu_exec_done_out, cpu_exec_pc_out} <= {1'b0, ~pc};
  endtask
endmodule

/* dv/test_bbc_unit.sv */
// Self-checking bench for the break-condition unit.
// Assumes the constants header, the package and the design files are compiled first.
`include "bbc_consts.svh"
module test_bbc_unit;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int AW = 24;
  logic core_clk, arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, emu_seq_mode = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic [31:0] avs_writedata = `BBC_WORD_ZERO, avs_readdata;
  logic [3:0] avs_byteenable = 4'hf;
  logic avs_waitrequest, brk_req, irq, cpu_cycle, cpu_write, cpu_lo, cpu_hi, cpu_fetch, cpu_done;
  logic [AW-1:0] cpu_addr, cpu_pc;
  logic [15:0] cpu_data;
  int n_mismatch = 0, checks = 0;
  bbc_unit #(.CH_NUM(2), .ADDR_W(AW)) i_dut (.core_clk_in(core_clk), .arst_n_in(arst_n),
    .avs_address_in(avs_address), .avs_read_in(avs_read), .avs_write_in(avs_write),
    .avs_writedata_in(avs_writedata), .avs_byteenable_in(avs_byteenable),
    .avs_readdata_out(avs_readdata), .avs_waitrequest_out(avs_waitrequest),
    .cpu_cycle_in(cpu_cycle), .cpu_addr_in(cpu_addr), .cpu_data_in(cpu_data),
    .cpu_write_in(cpu_write), .cpu_lane_lo_in(cpu_lo), .cpu_lane_hi_in(cpu_hi),
    .cpu_fetch_in(cpu_fetch), .cpu_exec_done_in(cpu_done), .cpu_exec_pc_in(cpu_pc),
    .emu_seq_mode_in(emu_seq_mode), .brk_req_out(brk_req), .irq_out(irq));
  bbc_cpu_model #(.ADDR_W(AW)) i_cpu (.core_clk_in(core_clk), .cpu_cycle_out(cpu_cycle),
    .cpu_addr_out(cpu_addr), .cpu_data_out(cpu_data), .cpu_write_out(cpu_write),
    .cpu_lane_lo_out(cpu_lo), .cpu_lane_hi_out(cpu_hi), .cpu_fetch_out(cpu_fetch),
    .cpu_exec_done_out(cpu_done), .cpu_exec_pc_out(cpu_pc));
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Flags {data ignore, after, addr ignore, enable}
  function automatic logic [31:0] ctl(input logic [3:0] f, input logic [1:0] sz, dr);
    return {24'h00_0000, dr, sz, f};
  endfunction
  task automatic bus_xfer(input logic rd, input logic [7:0] a, input logic [31:0] d,
                          output logic [31:0] q);
    int n;
    n = 0;
    @(posedge core_clk);
    {avs_read, avs_write} <= {rd, ~rd};
    avs_address <= a;
    avs_writedata <= d;
    do begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 20);
    q = avs_readdata;
    {avs_read, avs_write} <= 2'b00;
    if (n >= 20) begin
      n_mismatch++;
      $display("ERROR waitrequest expected 0 seen 1");
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_xfer(1'b0, a, d, q);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus_xfer(1'b1, a, `BBC_WORD_ZERO, q);
    chk(what, exp, q);
  endtask
  task automatic cfg(input logic [7:0] b, input logic [31:0] c, a, m, d);
    wr(b + 8'h04, a);
    wr(b + 8'h08, m);
    wr(b + 8'h0c, d);
    wr(b, c);
  endtask
  // Kind is {write, low lane, high lane, fetch}; break seen the cycle after
  task automatic cyc(input string what, input logic [AW-1:0] a, input logic [15:0] d,
                     input logic [3:0] k, input logic exp);
    i_cpu.bus(a, d, k[3], k[2], k[1], k[0]);
    #1;
    chk(what, 32'(exp), 32'(brk_req));
  endtask
  task automatic exe(input string what, input logic [AW-1:0] pc, input logic exp);
    i_cpu.done(pc);
    #1;
    chk(what, 32'(exp), 32'(brk_req));
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset();
    rdchk("status", `BBC_REG_STATUS, `BBC_WORD_ZERO);
    rdchk("irq mask", `BBC_REG_IRQ_MASK, `BBC_WORD_ZERO);
    rdchk("ch0 ctrl", 8'h20, `BBC_WORD_ZERO);
    $display("test reset done");
  endtask
  task automatic t_addr();
    cfg(8'h20, ctl(4'h9, `BBC_SZ_WORD, `BBC_DIR_ANY), 32'h0000_1234, 32'h0000_000f, 0);
    cyc("masked digit", 24'h00_1239, 16'h0000, 4'h6, 1'b1);
    cyc("unmasked digit", 24'h00_1249, 16'h0000, 4'h6, 1'b0);
    wr(8'h20, ctl(4'hb, `BBC_SZ_WORD, `BBC_DIR_ANY));
    cyc("addr ignored", 24'hff_0000, 16'h0000, 4'h6, 1'b1);
    $display("test addr done");
  endtask
  task automatic t_size();
    logic [3:0] ln [9] = '{4'h4, 4'h2, 4'h4, 4'h2, 4'h4, 4'h2, 4'h6, 4'h4, 4'h6};
    logic [15:0] dv [9] = '{16'h00a5, 16'ha500, 16'h00a4, 16'ha500, 16'h00a5, 16'ha400,
                            16'h5aa5, 16'h00a5, 16'h5aa4};
    logic ex [9] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
    wr(8'h2c, 32'h0000_5aa5);
    for (int i = 0; i < 9; i++) begin
      if (i % 3 == 0) begin
        wr(8'h20, ctl(4'h3, 2'(i / 3), `BBC_DIR_ANY));
      end
      cyc("size and lane", 24'h00_0000, dv[i], ln[i], ex[i]);
    end
    wr(8'h20, ctl(4'hb, `BBC_SZ_WORD, `BBC_DIR_ANY));
    cyc("data ignored", 24'h00_0000, 16'h1111, 4'h6, 1'b1);
    $display("test size done");
  endtask
  task automatic t_dir();
    for (int d = 0; d < 4; d++) begin
      wr(8'h20, ctl(4'hb, `BBC_SZ_WORD, 2'(d)));
      cyc("read cycle", 24'h00_0000, 16'h0000, 4'h6, d != 2);
      cyc("write cycle", 24'h00_0000, 16'h0000, 4'he, d != 1);
    end
    $display("test direction done");
  endtask
  task automatic t_disable();
    cfg(8'h20, ctl(4'h8, `BBC_SZ_WORD, `BBC_DIR_ANY), 32'h0000_1234, 0, 0);
    cyc("disabled", 24'h00_1234, 16'h0000, 4'h6, 1'b0);
    rdchk("kept addr", 8'h24, 32'h0000_1234);
    wr(8'h20, ctl(4'h9, `BBC_SZ_WORD, `BBC_DIR_ANY));
    cyc("enabled again", 24'h00_1234, 16'h0000, 4'h6, 1'b1);
    $display("test disable done");
  endtask
  task automatic t_delete();
    cfg(8'h30, ctl(4'hb, `BBC_SZ_WORD, `BBC_DIR_ANY), 32'h0000_5678, 0, 0);
    wr(`BBC_REG_CMD, 32'h0000_0200);
    rdchk("ch1 ctrl", 8'h30, `BBC_WORD_ZERO);
    rdchk("ch1 addr", 8'h34, `BBC_WORD_ZERO);
    rdchk("ch0 addr", 8'h24, 32'h0000_1234);
    cyc("one deleted", 24'h00_5678, 16'h0000, 4'h6, 1'b0);
    wr(`BBC_REG_CMD, 32'h0000_0001);
    rdchk("ch0 ctrl", 8'h20, `BBC_WORD_ZERO);
    wr(8'h20, ctl(4'h9, `BBC_SZ_WORD, `BBC_DIR_ANY));
    cyc("all deleted", 24'h00_1234, 16'h0000, 4'h6, 1'b0);
    $display("test delete done");
  endtask
  task automatic t_after();
    cfg(8'h20, ctl(4'h5, `BBC_SZ_HIGH, `BBC_DIR_WRITE), 32'h0000_0100, 0, 32'h0000_0077);
    cyc("fetch only", 24'h00_0100, 16'h0000, 4'h7, 1'b0);
    exe("executed", 24'h00_0100, 1'b1);
    cyc("fetch again", 24'h00_0100, 16'h0000, 4'h7, 1'b0);
    exe("other pc", 24'h00_0104, 1'b0);
    exe("pending dropped", 24'h00_0100, 1'b0);
    $display("test after done");
  endtask
  task automatic t_seq();
    wr(8'h20, ctl(4'h5, `BBC_SZ_HIGH, `BBC_DIR_WRITE) | 32'h0000_0500);
    rdchk("seq locked", 8'h20, ctl(4'h5, `BBC_SZ_HIGH, `BBC_DIR_WRITE) | 32'h0000_0800);
    emu_seq_mode <= 1'b1;
    wr(8'h20, ctl(4'h5, `BBC_SZ_HIGH, `BBC_DIR_WRITE) | 32'h0000_0500);
    rdchk("seq kept", 8'h20, ctl(4'h5, `BBC_SZ_HIGH, `BBC_DIR_WRITE) | 32'h0000_0d00);
    $display("test sequence done");
  endtask
  task automatic t_irq();
    rdchk("status sticky", `BBC_REG_STATUS, 32'h0000_0001);
    #1;
    chk("irq masked", `BBC_WORD_ZERO, 32'(irq));
    wr(`BBC_REG_IRQ_MASK, 32'h0000_0001);
    #1;
    chk("irq raised", 32'h0000_0001, 32'(irq));
    wr(`BBC_REG_STATUS, 32'h0000_0001);
    #1;
    chk("irq cleared", `BBC_WORD_ZERO, 32'(irq));
    rdchk("status cleared", `BBC_REG_STATUS, `BBC_WORD_ZERO);
    rdchk("unmapped", 8'hfc, `BBC_WORD_ZERO);
    $display("test irq done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    t_reset();
    t_addr();
    t_size();
    t_dir();
    t_disable();
    t_delete();
    t_after();
    t_seq();
    t_irq();
    test_done();
  end
  // Run needs about two hundred cycles; allow ample margin
  initial begin
    #200000;
    n_mismatch++;
    $display("ERROR watchdog expected finish seen hang");
    test_done();
  end
endmodule
